// ---- logic/utx_slave.sv ----
// utopia level 2 transmit slave with axi4-lite control
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module utx_slave (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // utopia transmit bus
  input  wire utx_pkg::utx_pins_s txbus,
  output logic                   txclav,
  output logic                   tx_tristate_clav,
  // cell fifo
  input  wire logic              full,
  output utx_pkg::utx_fifo_s     fifo_wr,
  // statistics and status
  output utx_pkg::utx_stat_s     stat,
  output logic                   overrun
);

  // ==========================================================
  // pin synchronisers
  utx_pkg::utx_pins_s sync1_ff; // first stage, read by second
  utx_pkg::utx_pins_s sync2_ff; // usable pin image

  // two flops on every bus pin
  // asynchronous clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= utx_pkg::PINS_RST;
      sync2_ff <= utx_pkg::PINS_RST;
    end else begin
      sync1_ff <= txbus;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // configuration registers
  logic [4:0]  cfg_addr_ff;  // own port address
  logic        cfg_width_ff; // 16-bit mode
  logic [15:0] cells_ff;     // cell start counter

  // ==========================================================
  // clav and selection
  logic sel_ff;     // port selected
  logic ok_ff;      // selected with room
  wire logic addr_hit;
  wire logic take;

  assign addr_hit = sync2_ff.addr == cfg_addr_ff;
  assign take = !sync2_ff.enb_n && sel_ff && ok_ff;

  // selection latches while enable is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_ff <= 1'h0;
      ok_ff  <= 1'h0;
    end else if (sync2_ff.enb_n) begin
      sel_ff <= addr_hit;
      ok_ff  <= addr_hit && !full;
    end
  end

  // clav, tristate and overrun flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txclav           <= 1'h0;
      tx_tristate_clav <= 1'h1;
      overrun          <= 1'h0;
    end else begin
      txclav           <= addr_hit && !full;
      tx_tristate_clav <= !addr_hit;
      overrun          <= !sync2_ff.enb_n && sel_ff && full;
    end
  end

  // ==========================================================
  // cell receiver
  utx_pkg::utx_cell_e state_ff; // cell progress
  logic [31:0] pack_ff;  // bytes gathered so far
  logic [2:0]  nb_ff;    // bytes held in pack_ff
  logic [5:0]  cnt_ff;   // bus words in cell
  logic        first_ff; // first write still due
  logic        perr_ff;  // parity error in cell
  logic        exc_ff;   // excess already counted

  // left-justify a partial word, zero padding
  function automatic logic [31:0] pad(
    input logic [31:0] p,
    input logic [2:0]  nb
  );
    logic [2:0] sh;
    sh = utx_pkg::NB_FULL - nb;
    if (nb == 3'h0) begin
      pad = 32'h0000_0000;
    end else begin
      pad = p << {sh[1:0], 3'h0};
    end
  endfunction

  wire logic        w16;      // 16-bit mode
  wire logic [5:0]  len;      // words per cell
  wire logic        par_ok;   // odd parity holds
  wire logic        soc_w;    // start word taken
  wire logic        data_w;   // body word taken
  wire logic        runt_det; // new cell cut old one
  wire logic        excess_w; // word beyond cell
  wire logic        in_w;     // word enters packer
  wire logic        par_bad;  // bad word in a cell
  wire logic [31:0] base_pack;
  wire logic [2:0]  base_nb;
  wire logic [5:0]  base_cnt;
  wire logic [31:0] new_pack;
  wire logic [2:0]  new_nb;
  wire logic [5:0]  new_cnt;
  wire logic        done;     // cell complete
  wire logic        wr_word;  // packed word ready

  assign w16 = cfg_width_ff;
  assign len = w16 ? utx_pkg::CELL_LEN16 : utx_pkg::CELL_LEN8;
  assign par_ok = w16 ? ^{sync2_ff.data, sync2_ff.prty}
                      : ^{sync2_ff.data[7:0], sync2_ff.prty};
  assign soc_w    = take && sync2_ff.soc;
  assign data_w   = take && !sync2_ff.soc;
  assign runt_det = soc_w && state_ff == utx_pkg::st_cell;
  assign excess_w = data_w && state_ff != utx_pkg::st_cell;
  assign in_w     = soc_w || (data_w && state_ff == utx_pkg::st_cell);
  assign par_bad  = in_w && !par_ok;

  assign base_pack = soc_w ? 32'h0000_0000 : pack_ff;
  assign base_nb   = soc_w ? 3'h0 : nb_ff;
  assign base_cnt  = soc_w ? 6'h00 : cnt_ff;
  assign new_pack = w16 ? {base_pack[15:0], sync2_ff.data}
                        : {base_pack[23:0], sync2_ff.data[7:0]};
  assign new_nb   = base_nb + (w16 ? utx_pkg::NB_STEP16
                                   : utx_pkg::NB_STEP8);
  assign new_cnt  = base_cnt + 6'h01;
  assign done     = in_w && new_cnt == len;
  assign wr_word  = in_w && (new_nb == utx_pkg::NB_FULL || done);

  // next values of the cell state
  utx_pkg::utx_cell_e nxt_state;
  assign nxt_state = soc_w ? utx_pkg::st_cell :
                     done  ? utx_pkg::st_over : state_ff;

  // cell progress registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= utx_pkg::st_idle;
      pack_ff  <= 32'h0000_0000;
      nb_ff    <= 3'h0;
      cnt_ff   <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      if (in_w) begin
        cnt_ff  <= new_cnt;
        nb_ff   <= wr_word ? 3'h0 : new_nb;
        pack_ff <= wr_word ? 32'h0000_0000 : new_pack;
      end
    end
  end

  // per-cell flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_ff <= 1'h0;
      perr_ff  <= 1'h0;
      exc_ff   <= 1'h0;
    end else begin
      first_ff <= soc_w ? !wr_word : (first_ff && !wr_word);
      perr_ff  <= soc_w ? par_bad : (perr_ff || par_bad);
      exc_ff   <= soc_w ? 1'h0 : (exc_ff || excess_w);
    end
  end

  // ==========================================================
  // fifo side and statistics
  utx_pkg::utx_fifo_s nxt_fifo;
  utx_pkg::utx_stat_s nxt_stat;
  wire logic perr_base;
  assign perr_base = soc_w ? 1'h0 : perr_ff;

  // runt flush takes the old partial word
  always_comb begin
    nxt_fifo = '0;
    nxt_fifo.valid = runt_det || wr_word;
    nxt_fifo.data  = runt_det ? pad(pack_ff, nb_ff)
                              : pad(new_pack, new_nb);
    nxt_fifo.soc = runt_det ? first_ff
                            : wr_word && (soc_w || first_ff);
    nxt_fifo.eoc = runt_det || done;
    nxt_fifo.discard = runt_det ||
                       (done && (perr_base || par_bad));
  end

  // statistics pulses
  always_comb begin
    nxt_stat.runt   = runt_det;
    nxt_stat.perr   = par_bad;
    nxt_stat.total  = soc_w;
    nxt_stat.excess = excess_w && !exc_ff;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_wr  <= '0;
      stat     <= '0;
      cells_ff <= 16'h0000;
    end else begin
      fifo_wr  <= nxt_fifo;
      stat     <= nxt_stat;
      cells_ff <= cells_ff + {15'h0000, soc_w};
    end
  end

  // ==========================================================
  // axi4-lite write channel
  logic       aw_hold_ff; // address held
  logic       w_hold_ff;  // data held
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wire logic aw_hs;
  wire logic w_hs;
  wire logic nxt_aw_hold;
  wire logic nxt_w_hold;
  wire logic do_wr;
  wire logic wr_cfg;

  assign aw_hs  = s_axi_awvalid && s_axi_awready;
  assign w_hs   = s_axi_wvalid && s_axi_wready;
  assign do_wr  = aw_hold_ff && w_hold_ff;
  assign wr_cfg = do_wr && awaddr_ff == utx_pkg::OFF_CFG;
  assign nxt_aw_hold = !do_wr && (aw_hold_ff || aw_hs);
  assign nxt_w_hold  = !do_wr && (w_hold_ff || w_hs);

  // take address and data in either order
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_ff    <= 1'h0;
      w_hold_ff     <= 1'h0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'h1;
      s_axi_wready  <= 1'h1;
    end else begin
      aw_hold_ff    <= nxt_aw_hold;
      w_hold_ff     <= nxt_w_hold;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      s_axi_awready <= !nxt_aw_hold && !(do_wr || s_axi_bvalid)
                       || (s_axi_bvalid && s_axi_bready);
      s_axi_wready  <= !nxt_w_hold && !(do_wr || s_axi_bvalid)
                       || (s_axi_bvalid && s_axi_bready);
    end
  end

  // response and config update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= utx_pkg::RESP_OKAY;
      cfg_addr_ff  <= utx_pkg::CFG_ADDR_RST;
      cfg_width_ff <= utx_pkg::CFG_WIDTH_RST;
    end else begin
      if (do_wr) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= wr_cfg ? utx_pkg::RESP_OKAY
                               : utx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
      if (wr_cfg && wstrb_ff[0]) begin
        cfg_addr_ff <= wdata_ff[4:0];
      end
      if (wr_cfg && wstrb_ff[1]) begin
        cfg_width_ff <= wdata_ff[utx_pkg::CFG_WIDTH_BIT];
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  wire logic        ar_hs;
  wire logic [31:0] rd_mux;
  wire logic        rd_hit;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign rd_hit = s_axi_araddr == utx_pkg::OFF_CFG  ||
                  s_axi_araddr == utx_pkg::OFF_STAT ||
                  s_axi_araddr == utx_pkg::OFF_CELLS;
  // register read select
  assign rd_mux =
    (s_axi_araddr == utx_pkg::OFF_CFG)
      ? {23'h0, cfg_width_ff, 3'h0, cfg_addr_ff} :
    (s_axi_araddr == utx_pkg::OFF_STAT)
      ? {28'h0, state_ff != utx_pkg::st_idle, sel_ff,
         overrun, full} :
    (s_axi_araddr == utx_pkg::OFF_CELLS)
      ? {16'h0000, cells_ff} : 32'h0000_0000;

  // one read answered per address beat
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= utx_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? utx_pkg::RESP_OKAY
                              : utx_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
    end
  end

  // ==========================================================
  // checks
  logic [3:0] wcnt_ff; // writes since first word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wcnt_ff <= 4'h0;
    end else if (fifo_wr.valid) begin
      wcnt_ff <= fifo_wr.eoc ? 4'h0 : wcnt_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sel_seq;
    sync2_ff.enb_n && addr_hit ##1 !sync2_ff.enb_n;
  endsequence

  clav_room_a: assert property (
    txclav |-> $past(addr_hit && !full))
    else $error("clav without room or address");
  clav_drive_a: assert property (
    !tx_tristate_clav |-> $past(addr_hit))
    else $error("clav driven for foreign address");
  port_select_a: assert property (
    sel_seq |-> sel_ff)
    else $error("own port not selected");
  take_enable_a: assert property (
    fifo_wr.valid && !fifo_wr.discard |-> $past(take))
    else $error("fifo write without enabled word");
  drop_end_a: assert property (
    fifo_wr.discard |-> fifo_wr.eoc && fifo_wr.valid)
    else $error("discard off last transfer");
  runt_drop_a: assert property (
    stat.runt |-> fifo_wr.discard)
    else $error("runt not discarded");
  parity_pulse_a: assert property (
    stat.perr |-> $past(!par_ok && take))
    else $error("parity pulse without mismatch");
  total_soc_a: assert property (
    $past(soc_w) |-> stat.total ##1 (stat.total == $past(soc_w)))
    else $error("cell start pulse wrong");
  excess_drop_a: assert property (
    $past(excess_w) |-> !fifo_wr.valid)
    else $error("excess word written");
  cell_words_a: assert property (
    fifo_wr.eoc && !fifo_wr.discard |-> wcnt_ff == utx_pkg::WR_LAST)
    else $error("good cell word count wrong");
  overrun_full_a: assert property (
    overrun |-> $past(full && sel_ff))
    else $error("overrun without full selection");
  reset_init_a: assert property (disable iff (1'b0)
    reset |=> !fifo_wr.valid && tx_tristate_clav)
    else $error("state not cleared by reset");

endmodule

`default_nettype wire

// ---- pkg/utx_pkg.sv ----
// constants, carriers and states for the utopia transmit slave
package utx_pkg;

  // ==========================================================
  // cell geometry
  localparam logic [5:0] CELL_LEN8  = 6'h35; // octets per cell
  localparam logic [5:0] CELL_LEN16 = 6'h1b; // words per cell
  localparam logic [2:0] NB_STEP8   = 3'h1;  // bytes per octet
  localparam logic [2:0] NB_STEP16  = 3'h2;  // bytes per word
  localparam logic [2:0] NB_FULL    = 3'h4;  // bytes per fifo word
  localparam logic [3:0] WR_LAST    = 4'hd;  // writes before eoc

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CFG   = 8'h00; // port address, width
  localparam logic [7:0] OFF_STAT  = 8'h04; // live status
  localparam logic [7:0] OFF_CELLS = 8'h08; // cell start count
  localparam int CFG_WIDTH_BIT     = 8;     // 16-bit select bit
  localparam logic [4:0] CFG_ADDR_RST  = 5'h00;
  localparam logic       CFG_WIDTH_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [4:0]  addr;  // poll and select address
    logic        enb_n; // transmit enable, low active
    logic [15:0] data;  // transmit data
    logic        soc;   // start of cell
    logic        prty;  // odd parity
  } utx_pins_s;

  typedef struct packed {
    logic [31:0] data;    // packed cell word
    logic        valid;   // word strobe
    logic        soc;     // first word of cell
    logic        eoc;     // last word of cell
    logic        discard; // drop this cell
  } utx_fifo_s;

  typedef struct packed {
    logic runt;   // runt cell seen
    logic perr;   // parity error seen
    logic total;  // start of cell seen
    logic excess; // excess octets seen
  } utx_stat_s;

  typedef enum logic [1:0] {
    st_idle, // no cell open
    st_cell, // cell filling
    st_over  // cell complete
  } utx_cell_e;

  localparam utx_pins_s PINS_RST = '{
    addr: 5'h1f, enb_n: 1'h1, data: 16'h0000,
    soc: 1'h0, prty: 1'h0};

endpackage

// ---- testbench/utx_atm_model.sv ----
// atm layer master model driving the utopia transmit bus
`timescale 1ns/1ps
`default_nettype none

module utx_atm_model (
  // clock
  input  wire logic          clk,
  // utopia transmit bus
  output utx_pkg::utx_pins_s txbus
);
  // idle bus at time zero
  initial txbus = utx_pkg::PINS_RST;

  // word i of cell c, upper byte is noise in 8-bit mode
  function automatic logic [15:0] word_of(input logic [7:0] c,
                                          input int i, input bit w16);
    word_of = w16 ? {c, 8'(i)} : {~(8'(i) ^ c), 8'(i) ^ c};
  endfunction

  // ==========================================================
  // bus tasks
  // poll one address
  task automatic poll(input logic [4:0] a);
    @(posedge clk);
    txbus.addr  <= a;
    txbus.enb_n <= 1'h1;
  endtask

  // cell of n words, one pause before word st
  task automatic send(input logic [4:0] a, input logic [7:0] c,
                      input int n, input bit w16, input int bad,
                      input int st);
    logic [15:0] d;
    d = 16'h0000;
    poll(a);
    for (int i = 0; i < n; i++) begin
      // pause keeps the port selected, data shows the inverse
      if (i == st) begin
        poll(a);
        txbus.data <= ~d;
      end
      @(posedge clk);
      d = word_of(c, i, w16);
      txbus.addr  <= 5'h1f;
      txbus.enb_n <= 1'h0;
      txbus.soc   <= 1'(i == 0);
      txbus.data  <= d;
      // odd parity, flipped on the bad word
      txbus.prty  <= (w16 ? ~^d : ~^d[7:0]) ^ 1'(i == bad);
    end
    // released bus shows the inverse
    @(posedge clk);
    txbus.enb_n <= 1'h1;
    txbus.soc   <= 1'h0;
    txbus.data  <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_utx_slave.sv ----
// self-checking bench for the utopia transmit slave
`timescale 1ns/1ps
`default_nettype none

module test_utx_slave;
  // ==========================================================
  // design pins and bench state
  logic               clk, reset, full, overrun, txclav, tx_tristate_clav;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic               s_axi_rready, ov_seen;
  utx_pkg::utx_pins_s txbus;
  utx_pkg::utx_fifo_s fifo_wr;
  utx_pkg::utx_stat_s stat;
  logic [34:0]        q[$];    // soc, eoc, discard, data
  int                 cnt[4];  // excess, total, perr, runt
  int                 fail_count, checked;

  utx_slave utx_slave_i (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txbus, .txclav,
    .tx_tristate_clav, .full, .fifo_wr, .stat, .overrun);
  utx_atm_model utx_atm_model_i (.clk, .txbus);

  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // monitor: fifo words, stat pulses, overrun
  always @(posedge clk) begin
    if (fifo_wr.valid === 1'h1)
      q.push_back({fifo_wr.soc, fifo_wr.eoc, fifo_wr.discard, fifo_wr.data});
    for (int b = 0; b < 4; b++)
      if (stat[b] === 1'h1)
        cnt[b]++;
    if (overrun === 1'h1)
      ov_seen = 1'h1;
  end

  // ==========================================================
  // shared tasks
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [39:0] e,
                     input logic [39:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // a wait that ran out ends the run
  task automatic give_up(input bit ok);
    if (!ok) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // fresh capture, off the sampling edge
  task automatic clr();
    @(negedge clk);
    q.delete();
    cnt = '{0, 0, 0, 0};
    ov_seen = 1'h0;
  endtask

  task automatic wait_q(input int n);
    for (int k = 0; k < 400 && q.size() < n; k++)
      @(posedge clk);
    give_up(q.size() >= n);
    repeat (8) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (int k = 0; k < 50 && s_axi_bvalid !== 1'h1; k++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    give_up(s_axi_bvalid === 1'h1);
    chk("bresp", 40'(er), 40'(s_axi_bresp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (int k = 0; k < 50 && s_axi_rvalid !== 1'h1; k++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    give_up(s_axi_rvalid === 1'h1);
    chk("rdata", 40'(ed), 40'(s_axi_rdata));
    chk("rresp", 40'(er), 40'(s_axi_rresp));
  endtask

  // packed fifo word j: earlier data high, zero padding low
  function automatic logic [31:0] exp_word(input logic [7:0] c,
                                           input int j, input bit w16);
    int          per = w16 ? 2 : 4;
    int          wb  = w16 ? 16 : 8;
    int          lim = w16 ? 27 : 53;
    logic [15:0] m   = w16 ? 16'hffff : 16'h00ff;
    exp_word = 32'h0;
    for (int k = 0; k < per; k++)
      if (per * j + k < lim)
        exp_word |= 32'(utx_atm_model_i.word_of(c, per * j + k, w16) & m)
                    << (32 - wb * (k + 1));
  endfunction

  task automatic chk_cell(input logic [7:0] c, input bit w16,
                          input int base, input bit disc);
    for (int j = 0; j < 14; j++)
      chk("fifo word", 40'({1'(j == 0), 1'(j == 13), disc & 1'(j == 13),
          exp_word(c, j, w16)}), 40'(q[base + j]));
  endtask

  // word count and pulse counts runt, perr, total, excess
  task automatic chk_st(input int nw, input logic [31:0] e);
    chk("word count", 40'(nw), 40'(q.size()));
    chk("stat pulses", 40'(e), 40'({8'(cnt[3]), 8'(cnt[2]), 8'(cnt[1]),
        8'(cnt[0])}));
  endtask

  // ==========================================================
  // scenarios, each judges its own results
  // reset values, then register access
  task automatic sc_regs();
    repeat (2) @(posedge clk);
    chk("reset outputs", 40'({3'h2, 36'h0}),
        40'({txclav, tx_tristate_clav, overrun, fifo_wr}));
    @(posedge clk);
    reset <= 1'h0;
    // configuration: port 5, 16-bit
    axi_wr(utx_pkg::OFF_CFG, 32'h105, utx_pkg::RESP_OKAY);
    axi_rd(utx_pkg::OFF_CFG, 32'h105, utx_pkg::RESP_OKAY);
    axi_wr(utx_pkg::OFF_STAT, 32'h0, utx_pkg::RESP_SLVERR);
    axi_rd(8'h0c, 32'h0, utx_pkg::RESP_SLVERR);
  endtask

  // polling own and foreign address, live status
  task automatic sc_poll();
    utx_atm_model_i.poll(5'h05);
    repeat (6) @(posedge clk);
    chk("clav own", 40'h2, 40'({txclav, tx_tristate_clav}));
    full <= 1'h1;
    repeat (6) @(posedge clk);
    chk("clav full", 40'h0, 40'(txclav));
    // selected, idle, not enabled, fifo full
    axi_rd(utx_pkg::OFF_STAT, 32'h5, utx_pkg::RESP_OKAY);
    full <= 1'h0;
    utx_atm_model_i.poll(5'h06);
    repeat (6) @(posedge clk);
    chk("clav other", 40'h1, 40'({txclav, tx_tristate_clav}));
  endtask

  // complete 16-bit cell
  task automatic sc_good16();
    clr();
    utx_atm_model_i.send(5'h05, 8'h11, 27, 1'h1, -1, -1);
    wait_q(14);
    chk_cell(8'h11, 1'h1, 0, 1'h0);
    chk_st(14, 32'h00000100);
    axi_rd(utx_pkg::OFF_CELLS, 32'h1, utx_pkg::RESP_OKAY);
  endtask

  // parity error, pause, two excess words
  task automatic sc_parity();
    clr();
    utx_atm_model_i.send(5'h05, 8'h22, 29, 1'h1, 5, 7);
    wait_q(14);
    chk_cell(8'h22, 1'h1, 0, 1'h1);
    chk_st(14, 32'h00010101);
  endtask

  // runt followed by a good cell
  task automatic sc_runt();
    clr();
    utx_atm_model_i.send(5'h05, 8'h33, 10, 1'h1, -1, -1);
    utx_atm_model_i.send(5'h05, 8'h44, 27, 1'h1, -1, -1);
    wait_q(20);
    chk("runt flush", 40'({3'h3, 32'h0}), 40'(q[5]));
    chk_cell(8'h44, 1'h1, 6, 1'h0);
    chk_st(20, 32'h01000200);
  endtask

  // 8-bit cell with a pause
  task automatic sc_good8();
    axi_wr(utx_pkg::OFF_CFG, 32'h005, utx_pkg::RESP_OKAY);
    clr();
    utx_atm_model_i.send(5'h05, 8'h80, 53, 1'h0, -1, 20);
    wait_q(14);
    chk_cell(8'h80, 1'h0, 0, 1'h0);
    chk_st(14, 32'h00000100);
  endtask

  // selection while full, full raised on the rising edge
  task automatic sc_full();
    full <= 1'h1;
    clr();
    utx_atm_model_i.send(5'h05, 8'h55, 6, 1'h0, -1, -1);
    repeat (8) @(posedge clk);
    chk("overrun", 40'h1, 40'(ov_seen));
    chk("words while full", 40'h0, 40'(q.size()));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hf - 4'h7;
    {s_axi_arvalid, s_axi_rready, full} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    fail_count = 0;
    checked = 0;
    sc_regs();
    sc_poll();
    sc_good16();
    sc_parity();
    sc_runt();
    sc_good8();
    sc_full();
    end_of_test();
  end
endmodule
`default_nettype wire
